// ### rtl/usb_ctrl_pkg.sv
package usb_ctrl_pkg;

    // register byte offsets
    localparam logic [7:0] OTG_LINE_OFFSET = 8'h00;
    localparam logic [7:0] MODULE_CTRL_OFFSET = 8'h04;
    localparam logic [7:0] ADDRESS_OFFSET = 8'h08;
    localparam logic [7:0] FRAME_LOW_OFFSET = 8'h0C;
    localparam logic [7:0] FRAME_HIGH_OFFSET = 8'h10;
    localparam logic [7:0] TOKEN_CMD_OFFSET = 8'h14;

    // line control fields
    localparam int POS_PULLUP_BIT = 7;
    localparam int NEG_PULLUP_BIT = 6;
    localparam int POS_PULLDOWN_BIT = 5;
    localparam int NEG_PULLDOWN_BIT = 4;
    localparam int BUS_POWER_BIT = 3;
    localparam int SW_LINE_EN_BIT = 2;
    localparam int CHARGE_BIT = 1;
    localparam int DISCHARGE_BIT = 0;

    // module control fields
    localparam int ENABLE_BIT = 0;
    localparam int PINGPONG_RST_BIT = 1;
    localparam int RESUME_BIT = 2;
    localparam int HOST_MODE_BIT = 3;
    localparam int TOKEN_BUSY_BIT = 5;

    // address fields
    localparam int SLOW_RATE_BIT = 7;
    localparam int FUNC_ADDR_MSB = 6;

    // reset values
    localparam logic [7:0] OTG_LINE_RESET = 8'h00;
    localparam logic [3:0] MODULE_CTRL_RESET = 4'h0;
    localparam logic [7:0] ADDRESS_RESET = 8'h00;
    localparam logic [7:0] FRAME_LOW_RESET = 8'h00;
    localparam logic [2:0] FRAME_HIGH_RESET = 3'h0;
    localparam logic [7:0] TOKEN_CMD_RESET = 8'h00;

    // frame timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_PERIOD_NS = 1000000;
    localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FRAME_CNT_W = 17;

endpackage : usb_ctrl_pkg

// ### rtl/usb_change_detect.sv
`timescale 1ns/10ps
module usb_change_detect
    import usb_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic prev;
    } cd_state_t;

    cd_state_t state_reg;
    cd_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.prev = level;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign rise = level & ~state_reg.prev;
    assign fall = ~level & state_reg.prev;
endmodule : usb_change_detect

// ### rtl/usb_frame_timer.sv
`timescale 1ns/10ps
module usb_frame_timer
    import usb_ctrl_pkg::*;
#(
    parameter int unsigned PERIOD = FRAME_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [FRAME_CNT_W-1:0] count;
    } ft_state_t;

    localparam logic [FRAME_CNT_W-1:0] LAST = FRAME_CNT_W'(PERIOD - 1);

    ft_state_t state_reg;
    ft_state_t state_next;

    // free count while running, parked at zero otherwise
    always_comb
    begin
        state_next = state_reg;
        if (!run || state_reg.count == LAST)
            state_next.count = '0;
        else
            state_next.count = state_reg.count + FRAME_CNT_W'(1);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign tick = run && state_reg.count == LAST;
endmodule : usb_frame_timer

// ### rtl/usb_otg_control_regs.sv
`timescale 1ns/10ps
// Contract
// RQ1: software-line enable set: line controls follow register; clear: hardware drives them
// RQ2: positive line pull-up bit drives positive pull-up enable
// RQ3: negative line pull-up bit drives negative pull-up enable
// RQ4: separate pull-down bits drive each line's pull-down enable
// RQ5: bus power bit requests VBUS power
// RQ6: charge bit applies VBUS charge path
// RQ7: discharge bit applies VBUS discharge path
// RQ8: ping-pong reset bit holds all buffer pointers at even bank
// RQ9: device mode: enable bit turns module on and off
// RQ10: host mode: enable bit emits a frame start token every 1 ms
// RQ11: software polls token busy before writing next token
// RQ12: any change of host mode bit resets host control logic
// RQ13: software holds resume 10 ms as function, 25 ms as host
// RQ14: host mode: clearing resume appends low-speed end of packet
// RQ15: low-speed select bit sets rate of next token
// RQ16: seven-bit function address, read/write, reset zero
// RQ17: received frame start loads low eight frame number bits
// RQ18: bits above seven read zero and ignore writes
// RQ19: upper three frame bits captured on same frame start event
// RQ20: all registers reset to zero; accessed as 32-bit words
module usb_otg_control_regs
    import usb_ctrl_pkg::*;
#(
    parameter int unsigned SOF_PERIOD = FRAME_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic hw_pos_pullup,
    input wire logic hw_neg_pullup,
    input wire logic hw_pos_pulldown,
    input wire logic hw_neg_pulldown,
    input wire logic sof_received,
    input wire logic [10:0] rx_frame_number,
    input wire logic token_done,
    output logic pos_line_pullup_en,
    output logic neg_line_pullup_en,
    output logic pos_line_pulldown_en,
    output logic neg_line_pulldown_en,
    output logic bus_power_request,
    output logic bus_power_charge_en,
    output logic bus_power_discharge_en,
    output logic pingpong_pointer_reset,
    output logic module_enable,
    output logic frame_start_gen_enable,
    output logic frame_start_send,
    output logic host_ctrl_reset,
    output logic resume_drive,
    output logic ls_eop_append,
    output logic slow_rate_token_select,
    output logic [6:0] function_address,
    output logic token_start,
    output logic [7:0] token_value
);
    typedef struct packed {
        logic [7:0] otg_line;
        logic [3:0] ctrl;
        logic token_busy;
        logic [7:0] address;
        logic [7:0] frame_low;
        logic [2:0] frame_high;
        logic [7:0] token;
        logic [31:0] rdata;
        logic [3:0] line_out;
        logic module_on;
        logic sof_on;
        logic sof_send;
        logic host_reset;
        logic ls_eop;
        logic tok_start;
        logic [FRAME_CNT_W-1:0] sof_gap;
    } regs_state_t;

    regs_state_t state_reg;
    regs_state_t state_next;

    logic host_rise;
    logic host_fall;
    logic resume_rise;
    logic resume_fall;
    logic sof_tick;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = a == off;
    endfunction : hit

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction : zext8

    usb_change_detect host_edge (
        .clk(clk),
        .rstn(rstn),
        .level(state_reg.ctrl[HOST_MODE_BIT]),
        .rise(host_rise),
        .fall(host_fall)
    );

    usb_change_detect resume_edge (
        .clk(clk),
        .rstn(rstn),
        .level(state_reg.ctrl[RESUME_BIT]),
        .rise(resume_rise),
        .fall(resume_fall)
    );

    usb_frame_timer #(
        .PERIOD(SOF_PERIOD)
    ) sof_timer (
        .clk(clk),
        .rstn(rstn),
        .run(state_reg.sof_on),
        .tick(sof_tick)
    );

    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = '0;
        state_next.tok_start = 1'b0;
        // register writes, low byte only
        if (wr_en)
        begin
            if (hit(addr, OTG_LINE_OFFSET))
                state_next.otg_line = wdata[7:0]; // [RQ18]
            if (hit(addr, MODULE_CTRL_OFFSET))
                state_next.ctrl = wdata[3:0];
            if (hit(addr, ADDRESS_OFFSET))
                state_next.address = wdata[7:0]; // [RQ16]
            if (hit(addr, TOKEN_CMD_OFFSET))
            begin
                state_next.token = wdata[7:0];
                state_next.tok_start = 1'b1;
            end
        end
        // busy set by token write wins over completion
        if (wr_en && hit(addr, TOKEN_CMD_OFFSET))
            state_next.token_busy = 1'b1; // [RQ11]
        else if (token_done || host_rise || host_fall)
            state_next.token_busy = 1'b0;
        // frame number capture
        if (sof_received)
        begin
            state_next.frame_low = rx_frame_number[7:0]; // [RQ17]
            state_next.frame_high = rx_frame_number[10:8]; // [RQ19]
        end
        // line resistor source select
        if (state_next.otg_line[SW_LINE_EN_BIT]) // [RQ1]
            state_next.line_out = state_next.otg_line[7:4]; // [RQ2] [RQ3] [RQ4]
        else
            state_next.line_out = {hw_pos_pullup, hw_neg_pullup,
                hw_pos_pulldown, hw_neg_pulldown};
        state_next.module_on = state_next.ctrl[ENABLE_BIT]
            & ~state_next.ctrl[HOST_MODE_BIT]; // [RQ9]
        state_next.sof_on = state_next.ctrl[ENABLE_BIT]
            & state_next.ctrl[HOST_MODE_BIT]; // [RQ10]
        state_next.sof_send = sof_tick & state_next.sof_on; // [RQ10]
        // cycles since the last frame start, for the period checks
        if (state_next.sof_send || !state_reg.sof_on)
            state_next.sof_gap = '0;
        else
            state_next.sof_gap = state_reg.sof_gap + FRAME_CNT_W'(1);
        state_next.host_reset = host_rise | host_fall; // [RQ12]
        state_next.ls_eop = resume_fall & state_reg.ctrl[HOST_MODE_BIT]; // [RQ14]
        // read data, unmapped reads zero
        if (rd_en)
        begin
            if (hit(addr, OTG_LINE_OFFSET))
                state_next.rdata = zext8(state_reg.otg_line); // [RQ18]
            else if (hit(addr, MODULE_CTRL_OFFSET))
                state_next.rdata = zext8({2'b00, state_reg.token_busy, 1'b0,
                    state_reg.ctrl});
            else if (hit(addr, ADDRESS_OFFSET))
                state_next.rdata = zext8(state_reg.address);
            else if (hit(addr, FRAME_LOW_OFFSET))
                state_next.rdata = zext8(state_reg.frame_low);
            else if (hit(addr, FRAME_HIGH_OFFSET))
                state_next.rdata = zext8({5'b00000, state_reg.frame_high});
            else if (hit(addr, TOKEN_CMD_OFFSET))
                state_next.rdata = zext8(state_reg.token);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= '0; // [RQ20]
            state_reg.otg_line <= OTG_LINE_RESET;
            state_reg.ctrl <= MODULE_CTRL_RESET;
            state_reg.address <= ADDRESS_RESET;
            state_reg.frame_low <= FRAME_LOW_RESET;
            state_reg.frame_high <= FRAME_HIGH_RESET;
            state_reg.token <= TOKEN_CMD_RESET;
        end
        else
            state_reg <= state_next;
    end

    assign rdata = state_reg.rdata;
    assign pos_line_pullup_en = state_reg.line_out[3]; // [RQ2]
    assign neg_line_pullup_en = state_reg.line_out[2]; // [RQ3]
    assign pos_line_pulldown_en = state_reg.line_out[1]; // [RQ4]
    assign neg_line_pulldown_en = state_reg.line_out[0]; // [RQ4]
    assign bus_power_request = state_reg.otg_line[BUS_POWER_BIT]; // [RQ5]
    assign bus_power_charge_en = state_reg.otg_line[CHARGE_BIT]; // [RQ6]
    assign bus_power_discharge_en = state_reg.otg_line[DISCHARGE_BIT]; // [RQ7]
    assign pingpong_pointer_reset = state_reg.ctrl[PINGPONG_RST_BIT]; // [RQ8]
    assign module_enable = state_reg.module_on;
    assign frame_start_gen_enable = state_reg.sof_on;
    assign frame_start_send = state_reg.sof_send;
    assign host_ctrl_reset = state_reg.host_reset;
    assign resume_drive = state_reg.ctrl[RESUME_BIT]; // [RQ13]
    assign ls_eop_append = state_reg.ls_eop;
    assign slow_rate_token_select = state_reg.address[SLOW_RATE_BIT]; // [RQ15]
    assign function_address = state_reg.address[FUNC_ADDR_MSB:0];
    assign token_start = state_reg.tok_start;
    assign token_value = state_reg.token;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_line_sw_follow: assert property ( // [RQ1]
        wr_en && hit(addr, OTG_LINE_OFFSET) && wdata[SW_LINE_EN_BIT]
        |=> {pos_line_pullup_en, neg_line_pullup_en, pos_line_pulldown_en,
            neg_line_pulldown_en} == $past(wdata[7:4]))
        else $error("line controls not from register");

    a_line_hw_follow: assert property ( // [RQ1]
        !state_next.otg_line[SW_LINE_EN_BIT]
        |=> pos_line_pullup_en == $past(hw_pos_pullup)
            && neg_line_pullup_en == $past(hw_neg_pullup)
            && pos_line_pulldown_en == $past(hw_pos_pulldown)
            && neg_line_pulldown_en == $past(hw_neg_pulldown))
        else $error("line controls not from hardware");

    a_power_bits: assert property ( // [RQ5]
        wr_en && hit(addr, OTG_LINE_OFFSET)
        |=> bus_power_request == $past(wdata[3])
            && bus_power_charge_en == $past(wdata[1])
            && bus_power_discharge_en == $past(wdata[0]))
        else $error("bus power bits wrong");

    a_pingpong_hold: assert property ( // [RQ8]
        wr_en && hit(addr, MODULE_CTRL_OFFSET)
        |=> pingpong_pointer_reset == $past(wdata[PINGPONG_RST_BIT]))
        else $error("pingpong reset wrong");

    a_mode_enable: assert property ( // [RQ9]
        !(module_enable && frame_start_gen_enable))
        else $error("device and host enables together");

    a_sof_gap: assert property ( // [RQ10]
        frame_start_send |=> !frame_start_send [*8])
        else $error("frame start too close");

    a_sof_off: assert property ( // [RQ10]
        !frame_start_gen_enable ##1 !frame_start_gen_enable |-> !frame_start_send)
        else $error("frame start while disabled");

    a_busy_set: assert property ( // [RQ11]
        wr_en && hit(addr, TOKEN_CMD_OFFSET)
        |=> state_reg.token_busy && token_start)
        else $error("token busy not set");

    a_host_reset: assert property ( // [RQ12]
        $changed(state_reg.ctrl[HOST_MODE_BIT]) |=> host_ctrl_reset)
        else $error("host reset missing");

    a_eop_append: assert property ( // [RQ14]
        $fell(resume_drive) && state_reg.ctrl[HOST_MODE_BIT]
        |=> ls_eop_append)
        else $error("end of packet not appended");

    a_frame_load: assert property ( // [RQ17]
        sof_received |=> state_reg.frame_low == $past(rx_frame_number[7:0])
            && state_reg.frame_high == $past(rx_frame_number[10:8])) // [RQ19]
        else $error("frame number not loaded");

    a_read_upper: assert property ( // [RQ18]
        rd_en |=> rdata[31:8] == 24'h000000)
        else $error("upper bits not zero");

    a_read_idle: assert property ( // [RQ20]
        !rd_en |=> rdata == 32'h00000000)
        else $error("read data outside read cycle");

    a_addr_read: assert property ( // [RQ16]
        wr_en && hit(addr, ADDRESS_OFFSET) ##1 rd_en && hit(addr, ADDRESS_OFFSET)
        |=> rdata[7:0] == $past(wdata[7:0], 2))
        else $error("address readback wrong");

    // frame spacing against the gap count
    a_sof_period: assert property ( // [RQ10]
        frame_start_send |-> $past(state_reg.sof_gap) == FRAME_CNT_W'(SOF_PERIOD - 1))
        else $error("frame start period wrong");

    a_sof_due: assert property ( // [RQ10]
        frame_start_gen_enable && state_reg.sof_gap == FRAME_CNT_W'(SOF_PERIOD - 1)
        |=> frame_start_send || !frame_start_gen_enable)
        else $error("frame start missing");

    a_token_clear: assert property ( // [RQ11]
        token_done && !(wr_en && hit(addr, TOKEN_CMD_OFFSET)) |=> !state_reg.token_busy)
        else $error("token busy not cleared");

    a_addr_fields: assert property ( // [RQ15]
        wr_en && hit(addr, ADDRESS_OFFSET)
        |=> slow_rate_token_select == $past(wdata[SLOW_RATE_BIT])
            && function_address == $past(wdata[FUNC_ADDR_MSB:0]))
        else $error("address fields wrong");

    a_device_enable: assert property ( // [RQ9]
        wr_en && hit(addr, MODULE_CTRL_OFFSET)
        |=> module_enable
            == ($past(wdata[ENABLE_BIT]) && !$past(wdata[HOST_MODE_BIT])))
        else $error("device enable wrong");

    a_host_frame_en: assert property ( // [RQ10]
        wr_en && hit(addr, MODULE_CTRL_OFFSET)
        |=> frame_start_gen_enable
            == ($past(wdata[ENABLE_BIT]) && $past(wdata[HOST_MODE_BIT])))
        else $error("frame start enable wrong");

    a_host_reset_cause: assert property ( // [RQ12]
        host_ctrl_reset |-> $past(state_reg.ctrl[HOST_MODE_BIT])
            != $past(state_reg.ctrl[HOST_MODE_BIT], 2))
        else $error("host reset without mode change");

    a_frame_hold: assert property ( // [RQ17]
        !sof_received |=> $stable(state_reg.frame_low))
        else $error("frame number changed without frame start");

    c_sof_sent: cover property (frame_start_send);
    c_host_reset: cover property (host_ctrl_reset);
    c_token_cycle: cover property (token_start ##[1:20] token_done);
    c_resume_host: cover property (ls_eop_append);
    c_sw_lines: cover property (state_reg.otg_line[SW_LINE_EN_BIT] && pos_line_pullup_en);
endmodule : usb_otg_control_regs

// ### verif/usb_far_side_model.sv
`timescale 1ns/10ps
module usb_far_side_model #(
    parameter int DONE_DELAY = 3
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sof_req,
    input wire logic [10:0] frame,
    input wire logic token_start,
    output logic sof_received,
    output logic [10:0] rx_frame_number,
    output logic token_done
);
    int cnt;
    // frame number valid only beside its pulse, scrambled otherwise
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sof_received <= 1'b0;
            rx_frame_number <= 11'h000;
            token_done <= 1'b0;
            cnt <= 0;
        end
        else
        begin
            sof_received <= sof_req;
            rx_frame_number <= sof_req ? frame : ~rx_frame_number;
            token_done <= (cnt == 1);
            cnt <= token_start ? DONE_DELAY : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule : usb_far_side_model

// ### verif/tb_usb_otg_control_regs.sv
`timescale 1ns/10ps
module tb_usb_otg_control_regs;
    import usb_ctrl_pkg::*;
    localparam int SOFP = 20;
    localparam int DLY = 3;
    logic clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sof_req = 1'b0, rd_seen = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0] hw = 4'h0;
    logic [10:0] frame = 11'h000, rxf;
    logic sofr, tdone, pu_p, pu_n, pd_p, pd_n, pwr, chg, dis, ppr, men, fse, fss, hcr, rsm, eop;
    logic slow, tok;
    logic [6:0] fa;
    logic [7:0] tokv;
    logic [31:0] exp_q[$];
    int n_errors = 0, num_checks = 0, n_sof = 0, n_hcr = 0, n_eop = 0, n_tok = 0, k, base;
    integer seed = 93095;

    always #5 clk = ~clk;

    usb_otg_control_regs #(.SOF_PERIOD(SOFP)) dut (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .hw_pos_pullup(hw[3]),
        .hw_neg_pullup(hw[2]), .hw_pos_pulldown(hw[1]), .hw_neg_pulldown(hw[0]),
        .sof_received(sofr), .rx_frame_number(rxf), .token_done(tdone),
        .pos_line_pullup_en(pu_p), .neg_line_pullup_en(pu_n), .pos_line_pulldown_en(pd_p),
        .neg_line_pulldown_en(pd_n), .bus_power_request(pwr), .bus_power_charge_en(chg),
        .bus_power_discharge_en(dis), .pingpong_pointer_reset(ppr), .module_enable(men),
        .frame_start_gen_enable(fse), .frame_start_send(fss), .host_ctrl_reset(hcr),
        .resume_drive(rsm), .ls_eop_append(eop), .slow_rate_token_select(slow),
        .function_address(fa), .token_start(tok), .token_value(tokv));

    usb_far_side_model #(.DONE_DELAY(DLY)) far (.clk(clk), .rstn(rstn), .sof_req(sof_req),
        .frame(frame), .token_start(tok), .sof_received(sofr), .rx_frame_number(rxf),
        .token_done(tdone));

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task summarize;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(negedge clk);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
    endtask : rd

    task waitc(input int n);
        repeat (n) @(negedge clk);
    endtask : waitc

    always @(posedge clk)
        rd_seen <= rd_en;

    // read data watcher and pulse counters
    always @(negedge clk)
    begin
        n_sof += fss;
        n_hcr += hcr;
        n_eop += eop;
        n_tok += tok;
        if (rd_seen === 1'b1)
            check("rdata", rdata, exp_q.pop_front());
    end

    initial
    begin
        #(10 * 20000);
        n_errors++;
        summarize();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 6; k++)
            rd(8'(4 * k), 32'h0);
        rd(8'h18, 32'h0);
        // software owned line controls
        for (k = 0; k < 8; k++)
        begin
            v = $random(seed) | 32'h4;
            wr(OTG_LINE_OFFSET, v);
            check("line", 32'({pu_p, pu_n, pd_p, pd_n}), 32'(v[7:4]));
            check("vbus", 32'({pwr, chg, dis}), 32'({v[3], v[1:0]}));
            rd(OTG_LINE_OFFSET, 32'(v[7:0]));
        end
        // hardware owned line controls
        wr(OTG_LINE_OFFSET, 32'hF0);
        for (k = 0; k < 4; k++)
        begin
            @(posedge clk);
            hw <= 4'($random(seed));
            waitc(2);
            check("hwline", 32'({pu_p, pu_n, pd_p, pd_n}), 32'(hw));
        end
        // address and unmapped place
        v = $random(seed);
        wr(ADDRESS_OFFSET, v);
        check("addr", 32'({slow, fa}), 32'(v[7:0]));
        rd(ADDRESS_OFFSET, 32'(v[7:0]));
        wr(8'h18, 32'hFF);
        rd(8'h18, 32'h0);
        rd(ADDRESS_OFFSET, 32'(v[7:0]));
        // write then read back with no gap
        v = $random(seed);
        @(posedge clk);
        addr <= ADDRESS_OFFSET;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        exp_q.push_back(32'(v[7:0]));
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        // frame number capture
        for (k = 0; k < 3; k++)
        begin
            @(posedge clk);
            frame <= 11'($random(seed));
            sof_req <= 1'b1;
            @(posedge clk);
            sof_req <= 1'b0;
            rd(FRAME_LOW_OFFSET, 32'(frame[7:0]));
            rd(FRAME_HIGH_OFFSET, 32'(frame[10:8]));
        end
        wr(FRAME_LOW_OFFSET, 32'hFF);
        rd(FRAME_LOW_OFFSET, 32'(frame[7:0]));
        // device mode enable and ping-pong reset
        wr(MODULE_CTRL_OFFSET, 32'h1);
        check("men", 32'({men, fse}), 32'h2);
        wr(MODULE_CTRL_OFFSET, 32'h3);
        check("ppr", 32'(ppr), 32'h1);
        rd(MODULE_CTRL_OFFSET, 32'h3);
        wr(MODULE_CTRL_OFFSET, 32'h0);
        check("off", 32'({men, ppr}), 32'h0);
        // host mode change and frame starts
        base = n_hcr;
        wr(MODULE_CTRL_OFFSET, 32'h8);
        waitc(3);
        check("hcr", 32'(n_hcr - base), 32'h1);
        base = n_sof;
        wr(MODULE_CTRL_OFFSET, 32'h9);
        check("fse", 32'({men, fse}), 32'h1);
        waitc(5 * SOFP + 5);
        wr(MODULE_CTRL_OFFSET, 32'h8);
        waitc(2 * SOFP);
        check("sof", 32'(n_sof - base), 32'h5);
        // resume in host and device mode
        base = n_eop;
        wr(MODULE_CTRL_OFFSET, 32'hC);
        check("rsm", 32'(rsm), 32'h1);
        wr(MODULE_CTRL_OFFSET, 32'h8);
        waitc(3);
        check("eop", 32'(n_eop - base), 32'h1);
        wr(MODULE_CTRL_OFFSET, 32'h4);
        wr(MODULE_CTRL_OFFSET, 32'h0);
        waitc(3);
        check("eopdev", 32'(n_eop - base), 32'h1);
        // token command and busy polling
        wr(MODULE_CTRL_OFFSET, 32'h8);
        base = n_tok;
        v = $random(seed);
        wr(TOKEN_CMD_OFFSET, v);
        rd(MODULE_CTRL_OFFSET, 32'h28);
        check("tokv", 32'(tokv), 32'(v[7:0]));
        waitc(DLY + 4);
        rd(MODULE_CTRL_OFFSET, 32'h08);
        rd(TOKEN_CMD_OFFSET, 32'(v[7:0]));
        check("tok", 32'(n_tok - base), 32'h1);
        waitc(2);
        summarize();
    end
endmodule : tb_usb_otg_control_regs
